// file: hdl/rdh_cfg.svh
// Offsets, fields, reset values and counts of the ring DMA block.
// Assumes inclusion by bare name.
`ifndef RDH_CFG_SVH
`define RDH_CFG_SVH
`define RDH_OFF_CTRL    4'h0
`define RDH_OFF_HDRLEN  4'h1
`define RDH_OFF_RXTYPE4 4'h2
`define RDH_OFF_RXTYPE5 4'h3
`define RDH_OFF_MACRX   4'h4
`define RDH_OFF_PCFGA   4'h5
`define RDH_OFF_ACCESS  4'h6
`define RDH_OFF_MASK1   4'h7
`define RDH_OFF_MASK2   4'h8
`define RDH_OFF_STAT1   4'h9
`define RDH_OFF_STAT2   4'ha
`define RDH_OFF_PSTATE  4'hb
`define RDH_STAT1_RST   32'h0000_3000
`define RDH_STAT2_RST   32'hcf00_0000
`define RDH_S1_RXC      10
`define RDH_S1_CDN      13
`define RDH_S1_IER      25
`define RDH_S2_DXC      16
`define RDH_S2_DNR      24
`define RDH_CTRL_SPLIT  3
`define RDH_CTRL_DEFER  4
`define RDH_PCFG_PAR    0
`define RDH_CHUNK_WORDS 7'h40
`define RDH_WORD_BYTES  14'h0004
`endif

// file: hdl/rdh_pkg.sv
// Types shared by the ring DMA and header split block.
// Assumes nothing of its surroundings.
package rdh_pkg;
   typedef enum logic [2:0] {D_IDLE, D_FETCH, D_MOVE, D_CHUNK, D_DIND, D_SIND} rdh_dma_e;
   typedef enum logic [2:0] {R_IDLE, R_HDR, R_DATA, R_DROP, R_HIND} rdh_rx_e;
   typedef struct packed {
      logic        wr;
      logic [3:0]  addr;
      logic [31:0] wdata;
   } rdh_ctl_s;
   typedef struct packed {
      logic [1:0]  kind;   // 0 destination, 1 source, 2 command register
      logic [2:0]  ring;
      logic [13:0] left;
   } rdh_dind_s;
   typedef struct packed {
      logic       split;
      logic       first;
      logic       last;
      logic       err;
      logic [2:0] chan;
   } rdh_rind_s;
endpackage : rdh_pkg

// file: hdl/ring_dma_header_split.sv
// Ring DMA, receive header split and status registers.
// Assumes memory ports and MAC share the clock.
// Notes on behaviour
// RL1 - Destination ring ready only via ready access
// RL2 - Per-ring length, parity, either port
// RL3 - First DMA descriptor fetches one destination
// RL4 - Data moves in 256-byte chunks
// RL5 - Full buffer writes indication, fetches next
// RL6 - Completion goes into last source descriptor
// RL7 - Command DMA carries one descriptor, 8K
// RL8 - Command done sets flag and interrupt
// RL9 - Split header always to channel four
// RL10 - Remainder to selected channel, split flagged
// RL11 - Header indication immediate or deferred
// RL12 - Abort after header gives data error
// RL13 - Header indication sets channel four complete
// RL14 - Control registers reset to zero
// RL15 - Free and done flags reset set
// RL16 - Destination not-ready flags reset set, rings 4 and 5 clear
// RL17 - Masks cleared, ports idle after reset
// RL18 - Port A config sets chip parity
// RL19 - Type filter: abort, ring four or ring five
// RL20 - No allocation check, overrun flags error
// RL21 - Software enables MAC receive last
// RL22 - Ring ready starts descriptor reads at once
`include "rdh_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module ring_dma_header_split (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire rdh_pkg::rdh_ctl_s ctl,
   output logic [31:0]            ctlRdata,
   output logic                   irq,
   output logic                   parityEn,
   input  wire logic              dmaStart,
   input  wire logic              dmaCmd,
   input  wire logic [2:0]        dmaRing,
   input  wire logic [13:0]       dmaLen,
   output logic                   dmaBusy,
   output logic                   dstReq,
   input  wire logic              dstValid,
   input  wire logic              dstOk,
   input  wire logic [13:0]       dstBufLen,
   input  wire logic [31:0]       srcData,
   input  wire logic              srcValid,
   output logic                   srcReady,
   output logic [31:0]            dstData,
   output logic                   dstDataValid,
   input  wire logic              dstDataReady,
   output logic                   indValid,
   output rdh_pkg::rdh_dind_s     ind,
   input  wire logic              rxValid,
   input  wire logic              rxFirst,
   input  wire logic              rxLast,
   input  wire logic              rxAbort,
   input  wire logic [2:0]        rxType,
   input  wire logic [31:0]       rxData,
   output logic                   rxOutValid,
   output logic                   rxOutChan,
   output logic [31:0]            rxOutData,
   output logic                   rxIndValid,
   output rdh_pkg::rdh_rind_s     rxInd,
   output logic                   rxAbortMac,
   input  wire logic              memOverrun
);
   // Counts drop a word at a time, floored at zero.
   function automatic logic [13:0] sub4(input logic [13:0] x);
      sub4 = (x > `RDH_WORD_BYTES) ? x - `RDH_WORD_BYTES : 14'h0000;
   endfunction : sub4

   logic [31:0] ctrlReg, ctrlNext, hdrLenReg, hdrLenNext, typ4Reg, typ4Next, typ5Reg, typ5Next;
   logic [31:0] macRxReg, macRxNext, pcfgReg, pcfgNext, mask1Reg, mask1Next, mask2Reg, mask2Next;
   logic [31:0] s1Reg, s1Next, s2Reg, s2Next, set1, set2, rdNext;
   logic        irqNext;
   rdh_pkg::rdh_dma_e dmaReg, dmaNext;
   logic [13:0] bytesReg, bytesNext, bufReg, bufNext;
   logic [6:0]  chunkReg, chunkNext;
   logic        cmdReg, cmdNext, reqNext, rdyNext, indVNext;
   logic [2:0]  ringReg, ringNext;
   rdh_pkg::rdh_dind_s indNext;
   logic        skVReg, skVNext, outVNext, take;
   logic [31:0] skDReg, skDNext, outDNext;
   rdh_pkg::rdh_rx_e rxReg, rxNext;
   logic [13:0] hdrLeftReg, hdrLeftNext;
   logic        chanReg, chanNext, oVNext, oChNext, riVNext, abNext, en4, en5;
   logic [31:0] oDNext;
   rdh_pkg::rdh_rind_s riNext;

   // Control and status registers; a hardware set beats a clear.
   always_comb begin
      ctrlNext = ctrlReg;
      hdrLenNext = hdrLenReg;
      typ4Next = typ4Reg;
      typ5Next = typ5Reg;
      macRxNext = macRxReg;
      pcfgNext = pcfgReg;
      mask1Next = mask1Reg;
      mask2Next = mask2Reg;
      s1Next = s1Reg;
      s2Next = s2Reg;
      if (ctl.wr) begin
         case (ctl.addr)
            `RDH_OFF_CTRL:    ctrlNext = ctl.wdata;
            `RDH_OFF_HDRLEN:  hdrLenNext = ctl.wdata;
            `RDH_OFF_RXTYPE4: typ4Next = ctl.wdata;
            `RDH_OFF_RXTYPE5: typ5Next = ctl.wdata;
            `RDH_OFF_MACRX:   macRxNext = ctl.wdata;
            `RDH_OFF_PCFGA:   pcfgNext = ctl.wdata;
            `RDH_OFF_MASK1:   mask1Next = ctl.wdata;
            `RDH_OFF_MASK2:   mask2Next = ctl.wdata;
            `RDH_OFF_STAT1:   s1Next = s1Reg & ~ctl.wdata;
            `RDH_OFF_STAT2:   s2Next = s2Reg & ~{8'h0, ctl.wdata[23:0]};
            // RL1 ready access clears
            `RDH_OFF_ACCESS:  s2Next = s2Reg & ~{ctl.wdata[7:0], 24'h0};
            default:          s2Next = s2Reg;
         endcase
      end
      // RL8 command start clears done
      if (dmaReg == rdh_pkg::D_IDLE && dmaStart && dmaCmd) begin
         s1Next[`RDH_S1_CDN] = 1'b0;
      end
      s1Next = s1Next | set1;
      s2Next = s2Next | set2;
      case (ctl.addr)
         `RDH_OFF_CTRL:    rdNext = ctrlReg;
         `RDH_OFF_HDRLEN:  rdNext = hdrLenReg;
         `RDH_OFF_RXTYPE4: rdNext = typ4Reg;
         `RDH_OFF_RXTYPE5: rdNext = typ5Reg;
         `RDH_OFF_MACRX:   rdNext = macRxReg;
         `RDH_OFF_PCFGA:   rdNext = pcfgReg;
         `RDH_OFF_MASK1:   rdNext = mask1Reg;
         `RDH_OFF_MASK2:   rdNext = mask2Reg;
         `RDH_OFF_STAT1:   rdNext = s1Reg;
         `RDH_OFF_STAT2:   rdNext = s2Reg;
         default:          rdNext = 32'h0; // RL17 port state idle
      endcase
      irqNext = |(s1Reg & mask1Reg) | |(s2Reg & mask2Reg);
   end

   // RL14 control clear, RL15 primary flags, RL16 not-ready set
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrlReg <= 32'h0;
         hdrLenReg <= 32'h0;
         typ4Reg <= 32'h0;
         typ5Reg <= 32'h0;
         macRxReg <= 32'h0;
         pcfgReg <= 32'h0;
         mask1Reg <= 32'h0;
         mask2Reg <= 32'h0;
         s1Reg <= `RDH_STAT1_RST;
         s2Reg <= `RDH_STAT2_RST;
         ctlRdata <= 32'h0;
         irq <= 1'b0;
         parityEn <= 1'b0;
      end else begin
         ctrlReg <= ctrlNext;
         hdrLenReg <= hdrLenNext;
         typ4Reg <= typ4Next;
         typ5Reg <= typ5Next;
         macRxReg <= macRxNext;
         pcfgReg <= pcfgNext;
         mask1Reg <= mask1Next;
         mask2Reg <= mask2Next;
         s1Reg <= s1Next;
         s2Reg <= s2Next;
         ctlRdata <= rdNext;
         irq <= irqNext;
         // RL18 port A parity
         parityEn <= pcfgNext[`RDH_PCFG_PAR];
      end
   end

   // DMA sequencer and two-entry skid buffer.
   always_comb begin
      dmaNext = dmaReg;
      bytesNext = bytesReg;
      bufNext = bufReg;
      chunkNext = chunkReg;
      cmdNext = cmdReg;
      ringNext = ringReg;
      indVNext = 1'b0;
      indNext = '0;
      set1 = 32'h0;
      set2 = 32'h0;
      take = srcValid && srcReady;
      case (dmaReg)
         rdh_pkg::D_IDLE: begin
            // RL7 one descriptor per command
            if (dmaStart) begin
               dmaNext = rdh_pkg::D_FETCH;
               bytesNext = dmaLen;
               cmdNext = dmaCmd;
               ringNext = dmaRing;
            end
         end
         // RL3 single destination fetch
         rdh_pkg::D_FETCH: begin
            if (dstValid && dstReq) begin
               if (dstOk) begin
                  bufNext = dstBufLen;
                  chunkNext = 7'h00;
                  dmaNext = rdh_pkg::D_MOVE;
               end else begin
                  // RL1 invalid descriptor
                  set2[`RDH_S2_DNR + ringReg] = 1'b1;
               end
            end
         end
         // RL4 chunk accounting
         rdh_pkg::D_MOVE: begin
            if (take) begin
               bytesNext = sub4(bytesReg);
               bufNext = sub4(bufReg);
               chunkNext = chunkReg + 7'h01;
               if (bytesNext == 14'h0000 || bufNext == 14'h0000) begin
                  dmaNext = rdh_pkg::D_DIND;
               end else if (chunkNext == `RDH_CHUNK_WORDS) begin
                  dmaNext = rdh_pkg::D_CHUNK;
               end
            end
         end
         rdh_pkg::D_CHUNK: begin
            chunkNext = 7'h00;
            dmaNext = rdh_pkg::D_MOVE;
         end
         // RL5 destination indication
         rdh_pkg::D_DIND: begin
            indVNext = 1'b1;
            indNext = '{kind: 2'h0, ring: ringReg, left: bufReg};
            set2[`RDH_S2_DXC + ringReg] = 1'b1;
            dmaNext = (bytesReg != 14'h0000) ? rdh_pkg::D_FETCH : rdh_pkg::D_SIND;
         end
         // RL6 source completion
         rdh_pkg::D_SIND: begin
            indVNext = 1'b1;
            indNext = '{kind: cmdReg ? 2'h2 : 2'h1, ring: ringReg, left: 14'h0000};
            // RL8 command done
            set1[`RDH_S1_CDN] = cmdReg;
            dmaNext = rdh_pkg::D_IDLE;
         end
         default: dmaNext = rdh_pkg::D_IDLE;
      endcase
      // RL22 fetch as soon as ready
      reqNext = (dmaNext == rdh_pkg::D_FETCH) && !s2Next[`RDH_S2_DNR + ringNext];
      outVNext = dstDataValid;
      outDNext = dstData;
      skVNext = skVReg;
      skDNext = skDReg;
      if (!dstDataValid || dstDataReady) begin
         outVNext = skVReg || take;
         outDNext = skVReg ? skDReg : srcData;
         skVNext = skVReg && take;
         skDNext = srcData;
      end else if (take) begin
         skVNext = 1'b1;
         skDNext = srcData;
      end
      rdyNext = !skVNext && (dmaNext == rdh_pkg::D_MOVE);
      // RL20 overrun flags error
      set1[`RDH_S1_IER] = memOverrun;
      if (riVNext) begin
         // RL13 receive complete
         set1[`RDH_S1_RXC + {31'h0, riNext.chan[0]}] = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dmaReg <= rdh_pkg::D_IDLE;
         bytesReg <= 14'h0000;
         bufReg <= 14'h0000;
         chunkReg <= 7'h00;
         cmdReg <= 1'b0;
         ringReg <= 3'h0;
         dmaBusy <= 1'b0;
         dstReq <= 1'b0;
         srcReady <= 1'b0;
         indValid <= 1'b0;
         ind <= '0;
         skVReg <= 1'b0;
         skDReg <= 32'h0;
         dstDataValid <= 1'b0;
         dstData <= 32'h0;
      end else begin
         dmaReg <= dmaNext;
         bytesReg <= bytesNext;
         bufReg <= bufNext;
         chunkReg <= chunkNext;
         cmdReg <= cmdNext;
         ringReg <= ringNext;
         dmaBusy <= dmaNext != rdh_pkg::D_IDLE;
         dstReq <= reqNext;
         srcReady <= rdyNext;
         indValid <= indVNext;
         ind <= indNext;
         skVReg <= skVNext;
         skDReg <= skDNext;
         dstDataValid <= outVNext;
         dstData <= outDNext;
      end
   end

   // Receive steering with header split. The MAC must leave one idle cycle after a deferred frame.
   always_comb begin
      rxNext = rxReg;
      hdrLeftNext = hdrLeftReg;
      chanNext = chanReg;
      oVNext = 1'b0;
      oChNext = chanReg;
      oDNext = rxData;
      riVNext = 1'b0;
      riNext = '0;
      abNext = 1'b0;
      en4 = typ4Reg[rxType];
      en5 = typ5Reg[rxType];
      case (rxReg)
         rdh_pkg::R_IDLE: begin
            if (rxValid && rxFirst) begin
               // RL19 type filter
               if (!en4 && !en5) begin
                  abNext = 1'b1;
                  rxNext = rxLast ? rdh_pkg::R_IDLE : rdh_pkg::R_DROP;
               end else begin
                  chanNext = !en4;
                  hdrLeftNext = sub4(hdrLenReg[13:0]);
                  oVNext = 1'b1;
                  if (ctrlReg[`RDH_CTRL_SPLIT]) begin
                     // RL9 header to channel four
                     oChNext = 1'b0;
                     if (rxLast || hdrLeftNext == 14'h0000) begin
                        riVNext = rxLast || !ctrlReg[`RDH_CTRL_DEFER];
                        riNext = '{split: 1'b1, first: 1'b1, last: 1'b1, err: 1'b0, chan: 3'h4};
                        rxNext = rxLast ? rdh_pkg::R_IDLE : rdh_pkg::R_DATA;
                     end else begin
                        rxNext = rdh_pkg::R_HDR;
                     end
                  end else begin
                     oChNext = !en4;
                     riVNext = rxLast;
                     riNext = '{split: 1'b0, first: 1'b1, last: 1'b1, err: 1'b0, chan: {2'h2, !en4}};
                     rxNext = rxLast ? rdh_pkg::R_IDLE : rdh_pkg::R_DATA;
                  end
               end
            end
         end
         rdh_pkg::R_HDR: begin
            if (rxAbort) begin
               rxNext = rdh_pkg::R_IDLE;
            end else if (rxValid) begin
               oVNext = 1'b1;
               oChNext = 1'b0;
               hdrLeftNext = sub4(hdrLeftReg);
               if (rxLast || hdrLeftNext == 14'h0000) begin
                  // RL11 immediate or held
                  riVNext = rxLast || !ctrlReg[`RDH_CTRL_DEFER];
                  riNext = '{split: 1'b1, first: 1'b1, last: 1'b1, err: 1'b0, chan: 3'h4};
                  rxNext = rxLast ? rdh_pkg::R_IDLE : rdh_pkg::R_DATA;
               end
            end
         end
         rdh_pkg::R_DATA: begin
            if (rxAbort || (rxValid && rxLast)) begin
               // RL10 remainder indication, RL12 abort error
               riVNext = 1'b1;
               riNext = '{split: ctrlReg[`RDH_CTRL_SPLIT], first: 1'b1, last: 1'b1,
                          err: rxAbort, chan: {2'h2, chanReg}};
               rxNext = (ctrlReg[`RDH_CTRL_SPLIT] && ctrlReg[`RDH_CTRL_DEFER]) ? rdh_pkg::R_HIND
                                                                               : rdh_pkg::R_IDLE;
            end
            oVNext = rxValid && !rxAbort;
         end
         rdh_pkg::R_DROP: begin
            if (rxAbort || (rxValid && rxLast)) begin
               rxNext = rdh_pkg::R_IDLE;
            end
         end
         rdh_pkg::R_HIND: begin
            // RL11 deferred header indication
            riVNext = 1'b1;
            riNext = '{split: 1'b1, first: 1'b1, last: 1'b1, err: 1'b0, chan: 3'h4};
            rxNext = rdh_pkg::R_IDLE;
         end
         default: rxNext = rdh_pkg::R_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rxReg <= rdh_pkg::R_IDLE;
         hdrLeftReg <= 14'h0000;
         chanReg <= 1'b0;
         rxOutValid <= 1'b0;
         rxOutChan <= 1'b0;
         rxOutData <= 32'h0;
         rxIndValid <= 1'b0;
         rxInd <= '0;
         rxAbortMac <= 1'b0;
      end else begin
         rxReg <= rxNext;
         hdrLeftReg <= hdrLeftNext;
         chanReg <= chanNext;
         rxOutValid <= oVNext;
         rxOutChan <= oChNext;
         rxOutData <= oDNext;
         rxIndValid <= riVNext;
         rxInd <= riNext;
         rxAbortMac <= abNext;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   AST_DNR_HOLD: assert property ((($past(s2Reg[31:24]) & ~s2Reg[31:24]) != 8'h00)
      |-> $past(ctl.wr && ctl.addr == `RDH_OFF_ACCESS)) else $error("not-ready dropped"); // RL1
   AST_FETCH_REQ: assert property ((dmaReg == rdh_pkg::D_IDLE && dmaStart && !s2Reg[`RDH_S2_DNR + dmaRing]
      && !ctl.wr) |=> dstReq) else $error("no destination fetch"); // RL3
   AST_CHUNK: assert property (chunkReg <= `RDH_CHUNK_WORDS) else $error("chunk too long"); // RL4
   AST_DIND_NEXT: assert property ((indValid && ind.kind == 2'h0)
      |-> $past(dmaReg == rdh_pkg::D_DIND) && dmaReg != rdh_pkg::D_MOVE) else $error("bad sequence"); // RL5
   AST_CDN: assert property ((indValid && ind.kind == 2'h2) |-> s1Reg[`RDH_S1_CDN]) else $error("done not set"); // RL8
   AST_HDR_CH4: assert property ((rxOutValid && $past(rxReg == rdh_pkg::R_HDR)) |-> !rxOutChan)
      else $error("header misrouted"); // RL9
   AST_RXC4: assert property ((rxIndValid && rxInd.chan == 3'h4) |=> s1Reg[`RDH_S1_RXC])
      else $error("rxc not set"); // RL13
   AST_ABORT: assert property (rxAbortMac |-> $past(rxValid && rxFirst && !typ4Reg[rxType]
      && !typ5Reg[rxType])) else $error("bad abort"); // RL19
   AST_IER: assert property ($past(memOverrun) |-> s1Reg[`RDH_S1_IER]) else $error("ier missing"); // RL20
   COV_CMD: cover property (indValid && ind.kind == 2'h2);
   COV_SPLIT: cover property (rxIndValid && rxInd.split && rxInd.chan == 3'h4);
   COV_ERR: cover property (rxIndValid && rxInd.err);
   COV_ABORT: cover property (rxAbortMac);
endmodule : ring_dma_header_split
`default_nettype wire

// file: verification/rdh_partner.sv
// Model of both port memories: descriptors, source words, word sink.
// Assumes the bench drives its controls at the falling edge and samples on the rising edge.
`timescale 1ns/10ps
`default_nettype none
module rdh_partner (
   input  wire logic        clk,
   input  wire logic        dstReq,
   output logic             dstValid,
   output logic             dstOk,
   output logic [13:0]      dstBufLen,
   output logic [31:0]      srcData,
   output logic             srcValid,
   input  wire logic        srcReady,
   output logic             dstDataReady,
   input  wire logic        okIn,
   input  wire logic [13:0] bufIn,
   input  wire logic        slow,
   input  wire logic        stall,
   input  wire logic        load,
   input  wire logic [15:0] words
);
   logic [15:0] left;
   logic [15:0] nxt;
   logic [1:0]  cnt;
   logic [1:0]  ph;
   logic        took;
   initial begin
      {dstValid, dstOk, dstBufLen, srcData, left, cnt, ph, took} = '0;
      dstDataReady = 1'b1;
   end
   // Advance only on words the block took.
   always @(posedge clk) took <= srcValid & srcReady;
   assign srcValid = (left != 16'h0);
   // one descriptor each
   // Idle descriptor lines toggle so stale values never pass.
   always @(negedge clk) begin
      cnt <= dstReq ? cnt + 2'h1 : 2'h0;
      dstValid <= dstReq && !dstValid && (!slow || cnt == 2'h3);
      dstOk <= dstReq ? okIn : ~dstOk;
      dstBufLen <= dstReq ? bufIn : ~dstBufLen;
      nxt = load ? words : left - {15'h0, took};
      left <= nxt;
      srcData <= (nxt != 16'h0) ? {16'ha5a5, nxt} : ~srcData;
      ph <= ph + 2'h1;
      dstDataReady <= !stall || ph == 2'h0;
   end
endmodule : rdh_partner
`default_nettype wire

// file: verification/ring_dma_header_split_test.sv
// Self-checking bench for the ring DMA block.
// Assumes the partner model and constants header are reachable.
`include "rdh_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module ring_dma_header_split_test;
   logic               clk, reset, irq, parityEn, dmaStart, dmaCmd, dmaBusy, dstReq, dstValid, dstOk;
   logic               srcValid, srcReady, dstDataValid, dstDataReady, indValid, rxValid, rxFirst, rxLast;
   logic               rxAbort, rxOutValid, rxOutChan, rxIndValid, rxAbortMac, memOverrun, okIn, slow, stall, load;
   logic [2:0]         dmaRing, rxType;
   logic [13:0]        dmaLen, dstBufLen, bufIn;
   logic [15:0]        words;
   logic [31:0]        ctlRdata, srcData, dstData, rxData, rxOutData;
   rdh_pkg::rdh_ctl_s  ctl;
   rdh_pkg::rdh_dind_s ind;
   rdh_pkg::rdh_rind_s rxInd;
   rdh_pkg::rdh_dind_s indQ[$];
   rdh_pkg::rdh_rind_s riQ[$];
   logic [32:0]        rxoQ[$];
   logic [31:0]        dstQ[$];
   int                 bad_count, checks, abortCnt, accCnt, gapAt;

   ring_dma_header_split u_ring_dma_header_split (.clk, .reset, .ctl, .ctlRdata, .irq, .parityEn, .dmaStart,
      .dmaCmd, .dmaRing, .dmaLen, .dmaBusy, .dstReq, .dstValid, .dstOk, .dstBufLen, .srcData, .srcValid,
      .srcReady, .dstData, .dstDataValid, .dstDataReady, .indValid, .ind, .rxValid, .rxFirst, .rxLast,
      .rxAbort, .rxType, .rxData, .rxOutValid, .rxOutChan, .rxOutData, .rxIndValid, .rxInd, .rxAbortMac,
      .memOverrun);
   rdh_partner u_rdh_partner (.clk, .dstReq, .dstValid, .dstOk, .dstBufLen, .srcData, .srcValid, .srcReady,
      .dstDataReady, .okIn, .bufIn, .slow, .stall, .load, .words);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Pulses last one cycle, so results are queued at their edge.
   always @(posedge clk) begin
      if (indValid) indQ.push_back(ind);
      if (rxOutValid) rxoQ.push_back({rxOutChan, rxOutData});
      if (rxIndValid) riQ.push_back(rxInd);
      if (dstDataValid && dstDataReady) dstQ.push_back(dstData);
      if (rxAbortMac) abortCnt++;
      if (srcValid && srcReady) accCnt++;
      else if (srcValid && accCnt != 0 && gapAt == 0) gapAt = accCnt;
   end
   // Words, flags and counts.
   task automatic cmpv(input logic [39:0] got, input logic [39:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmpv
   // Indications.
   task automatic cmpi(input logic [18:0] got, input logic [18:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmpi
   // A spare cycle first keeps one assignment per time step.
   task automatic regWr(input logic [3:0] a, input logic [31:0] d);
      @(negedge clk);
      ctl = '{wr: 1'b1, addr: a, wdata: d};
      @(negedge clk);
      ctl.wr = 1'b0;
   endtask : regWr
   task automatic regRd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      @(negedge clk);
      ctl.addr = a;
      @(negedge clk);
      cmpv(ctlRdata & m, e);
   endtask : regRd
   task automatic waitInd(input int n);
      for (int i = 0; i < 2000 && indQ.size() < n; i++)
         @(negedge clk);
      cmpv(indQ.size(), n);
   endtask : waitInd
   task automatic startDma(input logic c, input logic [2:0] r, input logic [13:0] n, input logic [15:0] w,
                           input logic [13:0] b, input logic ok);
      @(negedge clk);
      indQ.delete();
      dstQ.delete();
      {accCnt, gapAt} = '0;
      {okIn, bufIn, words, load, dmaCmd, dmaRing, dmaLen, dmaStart} = {ok, b, w, 1'b1, c, r, n, 1'b1};
      @(negedge clk);
      {load, dmaStart} = 2'b00;
   endtask : startDma
   // One word a cycle, idle cycles between frames.
   task automatic sendFrame(input logic [2:0] t, input int n, input logic ab);
      rxoQ.delete();
      riQ.delete();
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         {rxValid, rxFirst, rxLast, rxAbort, rxType} = {1'b1, i == 0, i == n - 1, ab && i == n - 1, t};
         rxData = 32'hc0de_0000 + i;
      end
      @(negedge clk);
      {rxValid, rxFirst, rxLast, rxAbort} = 4'h0;
      rxData = ~rxData;
      repeat (8) @(negedge clk);
   endtask : sendFrame
   task automatic testReset;
      regRd(`RDH_OFF_CTRL, '1, 32'h0);
      regRd(`RDH_OFF_MACRX, '1, 32'h0);
      regRd(`RDH_OFF_STAT1, '1, 32'h0000_3000);
      regRd(`RDH_OFF_STAT2, '1, 32'hcf00_0000);
      regRd(`RDH_OFF_MASK1, '1, 32'h0);
      regRd(`RDH_OFF_MASK2, '1, 32'h0);
      regRd(`RDH_OFF_PSTATE, '1, 32'h0);
      cmpv(irq, 0);
      regWr(`RDH_OFF_PCFGA, 32'h1);
      @(negedge clk);
      cmpv(parityEn, 1);
   endtask : testReset
   // Command DMA, ring not ready, sink stalling.
   task automatic testCmdDma;
      stall = 1'b1;
      startDma(1'b1, 3'h0, 14'h8, 16'h2, 14'h10, 1'b1);
      repeat (4) @(negedge clk);
      cmpv(dstReq, 0);
      regRd(`RDH_OFF_STAT1, 32'h2000, 32'h0);
      regWr(`RDH_OFF_ACCESS, 32'h1);
      waitInd(2);
      cmpi(indQ[0], {2'h0, 3'h0, 14'h8});
      cmpv({indQ[1].kind, indQ[1].ring}, {2'h2, 3'h0});
      repeat (8) @(negedge clk);
      cmpv(dstQ[0], {16'ha5a5, 16'h2});
      cmpv(dstQ[1], {16'ha5a5, 16'h1});
      cmpv(dmaBusy, 0);
      regRd(`RDH_OFF_STAT1, 32'h2000, 32'h2000);
      regWr(`RDH_OFF_MASK1, 32'h2000);
      @(negedge clk);
      cmpv(irq, 1);
      regWr(`RDH_OFF_STAT1, 32'h2000);
      @(negedge clk);
      cmpv(irq, 0);
      regWr(`RDH_OFF_MASK1, 32'h0);
   endtask : testCmdDma
   // 264-byte source DMA, 256-byte buffers, slow fetch.
   task automatic testSrcDma;
      {slow, stall} = 2'b10;
      regWr(`RDH_OFF_ACCESS, 32'h2);
      startDma(1'b0, 3'h1, 14'h108, 16'h42, 14'h100, 1'b1);
      @(negedge clk);
      cmpv(dstReq, 1);
      waitInd(3);
      cmpi(indQ[0], {2'h0, 3'h1, 14'h0});
      cmpi(indQ[1], {2'h0, 3'h1, 14'hf8});
      cmpv(indQ[2].kind, 2'h1);
      cmpv(gapAt, 64);
      cmpv(dstQ.size(), 66);
   endtask : testSrcDma
   // Invalid descriptor: not ready until a ready access.
   task automatic testBadDst;
      regWr(`RDH_OFF_ACCESS, 32'h4);
      startDma(1'b1, 3'h2, 14'h4, 16'h1, 14'h10, 1'b0);
      repeat (8) @(negedge clk);
      cmpv(dstReq, 0);
      regRd(`RDH_OFF_STAT2, 32'h0400_0000, 32'h0400_0000);
      okIn = 1'b1;
      regWr(`RDH_OFF_ACCESS, 32'h4);
      waitInd(2);
   endtask : testBadDst
   task automatic testSplit;
      regWr(`RDH_OFF_RXTYPE4, 32'h5);
      regWr(`RDH_OFF_RXTYPE5, 32'h6);
      regWr(`RDH_OFF_HDRLEN, 32'h4);
      regWr(`RDH_OFF_CTRL, 32'h8);
      regWr(`RDH_OFF_MACRX, 32'h3);
      sendFrame(3'h1, 3, 1'b0);
      cmpv(rxoQ.size(), 3);
      cmpv(rxoQ[0], {1'b0, 32'hc0de_0000});
      cmpv(rxoQ[2], {1'b1, 32'hc0de_0002});
      cmpv(riQ.size(), 2);
      cmpi(riQ[0], 7'h74);
      cmpi(riQ[1], 7'h75);
      regRd(`RDH_OFF_STAT1, 32'h400, 32'h400);
      regWr(`RDH_OFF_CTRL, 32'h18);
      sendFrame(3'h1, 2, 1'b0);
      cmpi(riQ[0], 7'h75);
      cmpi(riQ[1], 7'h74);
      regWr(`RDH_OFF_CTRL, 32'h8);
      sendFrame(3'h1, 3, 1'b1);
      cmpi(riQ[1], 7'h7d);
      regWr(`RDH_OFF_CTRL, 32'h0);
      sendFrame(3'h2, 1, 1'b0);
      cmpv(rxoQ[0], {1'b0, 32'hc0de_0000});
      sendFrame(3'h3, 1, 1'b0);
      cmpv({abortCnt[3:0], rxoQ.size()}, {4'h1, 32'h0});
      @(negedge clk);
      memOverrun = 1'b1;
      @(negedge clk);
      memOverrun = 1'b0;
      regRd(`RDH_OFF_STAT1, 32'h0200_0000, 32'h0200_0000);
   endtask : testSplit
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run
   // Tests need a few hundred cycles.
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      complete_run();
   end
   initial begin
      {ctl, dmaStart, dmaCmd, dmaRing, dmaLen, rxValid, rxFirst, rxLast, rxAbort, rxType, rxData} = '0;
      {memOverrun, okIn, slow, stall, load, words, bufIn} = '0;
      {bad_count, checks, abortCnt, accCnt, gapAt} = '0;
      reset = 1'b1;
      repeat (12) @(negedge clk);
      reset = 1'b0;
      testReset();
      testCmdDma();
      testSrcDma();
      testBadDst();
      testSplit();
      complete_run();
   end
endmodule : ring_dma_header_split_test
`default_nettype wire
